/* rtl/psmc_defs.vh */
// Contract
// - Slow-down divides all oscillator-derived rates, clock output and watchdog, by eight.
// - Slow-down takes effect at most two machine cycles after the bit is set.
// - Clearing the slow-down bit returns the block to the full clock rate.
// - Idle stops the CPU clock; peripherals except the watchdog keep running.
// - Idle needs the enable bit, then the start bit, on consecutive instructions.
// - Any enabled interrupt ends idle; execution resumes after the start instruction.
// - Port pins hold their entry state in idle; active alternate functions keep driving.
// - Address latch and program fetch strobes stay high during idle.
// - Power down needs arm without start, then start on the very next instruction.
// - Arm and start bits of power down clear themselves after being set.
// - Start instruction is the last one; only a hardware reset ends power down.
// - Software power down stops both oscillators while internal RAM is kept.
// - A high save-enable pin blocks every software power saving mode; the code blocks idle and power down but still allows slow-down.
// - A high save-enable pin starts the watchdog right after reset.
// - A low save-enable pin allows all modes; software may start the watchdog.
// - Save-enable may change at run time without touching the watchdog.
// - A low hard sleep pin enters hardware power down regardless of save-enable.
// - Hardware power down stops, turns off oscillators and floats pins.
// - Software modes are selected in one power control register at 87h.
// - Hard sleep pin is sampled per machine cycle; reset, clear watchdog, then stop.
// - On release pins go to reset state, oscillators restart, reset held till stable.
// - Active reset overrides hardware power down and performs a normal reset.
`ifndef PSMC_DEFS_VH
`define PSMC_DEFS_VH
`define PSMC_ADDR_W         8
`define PSMC_POWER_CONTROL_OFS       8'h87
`define PSMC_WDOG_OFS       8'h88
`define PSMC_STAT_OFS       8'h89
`define PSMC_BIT_SD         0
`define PSMC_BIT_IDLE       1
`define PSMC_BIT_CPU_PAUSE_START_BIT       2
`define PSMC_BIT_PDE        3
`define PSMC_BIT_PDS        4
`define PSMC_BIT_WDSTART    0
`define PSMC_POWER_CONTROL_RST       8'h00
`define PSMC_MC_CYCLES      4'hc
`define PSMC_SD_DIV         4'h8
`define PSMC_SD_SYNC_MC     2'h2
`define PSMC_HPD_RST_MC     4'h2
`define PSMC_OSC_START_MC   8'h10
`endif

/* rtl/psmc_power_saving_mode_control.v */
// The Wishbone register port was decided locally.
`timescale 1ns/10ps
`include "psmc_defs.vh"
// Power saving mode controller with a classic Wishbone slave for the control registers.
// One machine cycle is twelve clocks; in slow-down each machine cycle takes eight times longer.
module psmc_power_saving_mode_control
(
  input  wire        clock,
  input  wire        reset,
  input  wire [7:0]  wbAdr,
  input  wire [7:0]  wbDatI,
  output reg  [7:0]  wbDatO,
  input  wire        wbWe,
  input  wire        wbSel,
  input  wire        wbCyc,
  input  wire        wbStb,
  output reg         wbAck,
  input  wire        resetPin,
  input  wire        hardSleepPinN,
  input  wire        saveEnableWdogStartPin,
  input  wire        interruptPending,
  input  wire        oscStable,
  output reg         machineCycleTick,
  output reg         clockOutPin,
  output reg         cpuClockEnable,
  output reg         periphClockEnable,
  output reg         watchdogTick,
  output reg         watchdogRun,
  output reg         watchdogResetFlag,
  output reg         oscEnable,
  output reg         rcOscEnable,
  output reg         internalReset,
  output reg         portHold,
  output reg         pinFloat,
  output reg         addrLatchStrobe,
  output reg         programFetchStrobeN,
  output reg         idleActive,
  output reg         sleepActive,
  output reg         slowActive
);

  // Mode states.
  localparam [2:0] ST_RUN   = 3'h0;
  localparam [2:0] ST_IDLE  = 3'h1;
  localparam [2:0] ST_SLEEP = 3'h2;
  localparam [2:0] ST_HRST  = 3'h3;
  localparam [2:0] ST_HOFF  = 3'h4;
  localparam [2:0] ST_WAKE  = 3'h5;

  reg  [1:0] resetSync_r;
  reg  [1:0] hardSync_r;
  reg  [1:0] saveSync_r;
  reg  [1:0] irqSync_r;
  reg  [1:0] oscSync_r;
  reg  [2:0] state_r;
  reg  [2:0] state_nxt;
  reg        clkDivBit_r;
  reg        cpuPauseEnBit_r;
  reg        sleepArmBit_r;
  reg        prevArmWrite_r;
  reg        prevIdleWrite_r;
  reg        wdogSoftStart_r;
  reg        autoStartDone_r;
  reg  [3:0] preDiv_r;
  reg  [3:0] slowDiv_r;
  reg        slowEff_r;
  reg  [1:0] syncCnt_r;
  reg  [7:0] stepCnt_r;
  reg        clkOutPhase_r;

  wire       pinReset   = resetSync_r[1];
  wire       hardSleep  = ~hardSync_r[1];
  wire       saveBlock  = saveSync_r[1];
  wire       wbWrite    = wbCyc & wbStb & wbWe & wbSel & ~wbAck;
  wire       pconWrite  = regWriteHit(`PSMC_POWER_CONTROL_OFS);
  wire       preWrap    = (preDiv_r == `PSMC_MC_CYCLES - 4'h1);
  wire       slowWrap   = (slowDiv_r == `PSMC_SD_DIV - 4'h1);
  wire       mcTick     = preWrap & (~slowEff_r | slowWrap);
  wire       softReset  = pinReset | (state_r == ST_HRST) | (state_r == ST_WAKE);

  // Reads one register by index; unmapped addresses answer zero.
  function [7:0] regRead;
    input [7:0] adr;
    begin
      case (adr)
        `PSMC_POWER_CONTROL_OFS: regRead = {5'h00, cpuPauseEnBit_r, 1'b0, clkDivBit_r};
        `PSMC_WDOG_OFS: regRead = {7'h00, watchdogRun};
        `PSMC_STAT_OFS: regRead = {4'h0, slowEff_r, watchdogResetFlag, state_r == ST_HOFF,
                                   state_r == ST_IDLE};
        default:        regRead = 8'h00;
      endcase
    end
  endfunction

  // Write strobe for one register offset.
  function regWriteHit;
    input [7:0] ofs;
    begin
      regWriteHit = wbWrite & (wbAdr == ofs);
    end
  endfunction

  // True in the two states in which both oscillators are stopped.
  function oscOff;
    input [2:0] st;
    begin
      oscOff = (st == ST_SLEEP) | (st == ST_HOFF);
    end
  endfunction

  // True in the states in which the oscillator still clocks the peripherals.
  function clocked;
    input [2:0] st;
    begin
      clocked = (st == ST_RUN) | (st == ST_IDLE);
    end
  endfunction

  // Two-flop synchronisers on every pin input.
  always @(posedge clock)
  begin
    resetSync_r <= {resetSync_r[0], resetPin};
    hardSync_r  <= {hardSync_r[0], hardSleepPinN};
    saveSync_r  <= {saveSync_r[0], saveEnableWdogStartPin};
    irqSync_r   <= {irqSync_r[0], interruptPending};
    oscSync_r   <= {oscSync_r[0], oscStable};
  end

  // Wishbone slave: one registered answer a cycle after the request, ack dropped the cycle after.
  always @(posedge clock)
  begin
    if (reset)
    begin
      wbAck  <= 1'b0;
      wbDatO <= 8'h00;
    end
    else
    begin
      wbAck  <= wbCyc & wbStb & ~wbAck;
      wbDatO <= regRead(wbAdr);
    end
  end

  // Next mode from pins, control writes and wake sources.
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN:
      begin
        if (hardSleep & mcTick)
          state_nxt = ST_HRST;
        else if (pconWrite & ~saveBlock & wbDatI[`PSMC_BIT_PDS] & ~wbDatI[`PSMC_BIT_PDE]
                 & prevArmWrite_r & sleepArmBit_r)
          state_nxt = ST_SLEEP;
        else if (pconWrite & ~saveBlock & wbDatI[`PSMC_BIT_CPU_PAUSE_START_BIT] & prevIdleWrite_r
                 & cpuPauseEnBit_r)
          state_nxt = ST_IDLE;
      end
      ST_IDLE:
      begin
        if (hardSleep & mcTick)
          state_nxt = ST_HRST;
        else if (irqSync_r[1])
          state_nxt = ST_RUN;
      end
      ST_SLEEP:
        state_nxt = ST_SLEEP;
      ST_HRST:
        if (mcTick & (stepCnt_r == {4'h0, `PSMC_HPD_RST_MC} - 8'h01))
          state_nxt = ST_HOFF;
      ST_HOFF:
        if (~hardSleep)
          state_nxt = ST_WAKE;
      ST_WAKE:
        if (oscSync_r[1] & (stepCnt_r == `PSMC_OSC_START_MC))
          state_nxt = ST_RUN;
      default:
        state_nxt = ST_RUN;
    endcase
    if (pinReset)
      state_nxt = ST_RUN;
  end

  // Mode state, control bits and step counter.
  always @(posedge clock)
  begin
    if (reset)
    begin
      state_r         <= ST_RUN;
      clkDivBit_r     <= 1'b0;
      cpuPauseEnBit_r <= 1'b0;
      sleepArmBit_r   <= 1'b0;
      prevArmWrite_r  <= 1'b0;
      prevIdleWrite_r <= 1'b0;
      stepCnt_r       <= 8'h00;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_nxt != state_r)
        stepCnt_r <= 8'h00;
      else if (state_r == ST_WAKE ? (preWrap & stepCnt_r != `PSMC_OSC_START_MC) : mcTick)
        stepCnt_r <= stepCnt_r + 8'h01;
      if (softReset)
      begin
        clkDivBit_r     <= 1'b0;
        cpuPauseEnBit_r <= 1'b0;
        sleepArmBit_r   <= 1'b0;
        prevArmWrite_r  <= 1'b0;
        prevIdleWrite_r <= 1'b0;
      end
      else if (pconWrite)
      begin
        clkDivBit_r     <= wbDatI[`PSMC_BIT_SD];
        cpuPauseEnBit_r <= wbDatI[`PSMC_BIT_IDLE] & ~wbDatI[`PSMC_BIT_CPU_PAUSE_START_BIT];
        sleepArmBit_r   <= wbDatI[`PSMC_BIT_PDE];
        prevArmWrite_r  <= wbDatI[`PSMC_BIT_PDE] & ~wbDatI[`PSMC_BIT_PDS];
        prevIdleWrite_r <= wbDatI[`PSMC_BIT_IDLE] & ~wbDatI[`PSMC_BIT_CPU_PAUSE_START_BIT];
      end
      else if (wbWrite)
      begin
        sleepArmBit_r   <= 1'b0;
        prevArmWrite_r  <= 1'b0;
        prevIdleWrite_r <= 1'b0;
        cpuPauseEnBit_r <= 1'b0;
      end
    end
  end

  // Machine cycle prescaler; only the bus reset stops it, so reset and wake phases keep counting.
  always @(posedge clock)
  begin
    if (reset)
      preDiv_r <= 4'h0;
    else
      preDiv_r <= preWrap ? 4'h0 : preDiv_r + 4'h1;
  end

  // Slow-down divider and its synchronisation delay; any internal reset returns to full rate.
  always @(posedge clock)
  begin
    if (reset | softReset)
    begin
      slowDiv_r <= 4'h0;
      slowEff_r <= 1'b0;
      syncCnt_r <= 2'h0;
    end
    else
    begin
      if (preWrap)
        slowDiv_r <= (slowWrap | ~slowEff_r) ? 4'h0 : slowDiv_r + 4'h1;
      if (clkDivBit_r == slowEff_r)
        syncCnt_r <= 2'h0;
      else if (mcTick)
      begin
        syncCnt_r <= syncCnt_r + 2'h1;
        if (syncCnt_r == `PSMC_SD_SYNC_MC - 2'h1)
          slowEff_r <= clkDivBit_r;
      end
    end
  end

  // Watchdog start policy and status flag.
  always @(posedge clock)
  begin
    if (reset)
    begin
      wdogSoftStart_r   <= 1'b0;
      autoStartDone_r   <= 1'b0;
      watchdogResetFlag <= 1'b0;
    end
    else if (softReset)
    begin
      wdogSoftStart_r   <= 1'b0;
      autoStartDone_r   <= 1'b0;
      watchdogResetFlag <= (state_r == ST_WAKE) | (state_r == ST_HOFF);
    end
    else
    begin
      if (~autoStartDone_r)
      begin
        autoStartDone_r <= 1'b1;
        wdogSoftStart_r <= saveBlock;
      end
      else if (regWriteHit(`PSMC_WDOG_OFS) & wbDatI[`PSMC_BIT_WDSTART])
        wdogSoftStart_r <= 1'b1;
    end
  end

  // Machine cycle pulses and the clock output, gated by mode.
  always @(posedge clock)
  begin
    if (reset)
    begin
      machineCycleTick  <= 1'b0;
      clockOutPin       <= 1'b0;
      clkOutPhase_r     <= 1'b0;
      cpuClockEnable    <= 1'b0;
      periphClockEnable <= 1'b0;
      watchdogTick      <= 1'b0;
      watchdogRun       <= 1'b0;
    end
    else
    begin
      if (mcTick)
        clkOutPhase_r <= ~clkOutPhase_r;
      machineCycleTick  <= mcTick & (state_r == ST_RUN);
      clockOutPin       <= clkOutPhase_r & clocked(state_r);
      cpuClockEnable    <= mcTick & (state_r == ST_RUN);
      periphClockEnable <= mcTick & clocked(state_r);
      watchdogTick      <= mcTick & (state_r == ST_RUN) & wdogSoftStart_r;
      watchdogRun       <= wdogSoftStart_r & ~softReset;
    end
  end

  // Oscillator enables and internal reset; both oscillators stop in either sleep state.
  always @(posedge clock)
  begin
    if (reset)
    begin
      oscEnable     <= 1'b1;
      rcOscEnable   <= 1'b1;
      internalReset <= 1'b1;
    end
    else
    begin
      oscEnable     <= ~oscOff(state_r);
      rcOscEnable   <= ~oscOff(state_r);
      internalReset <= softReset;
    end
  end

  // Pin control: hold in idle and sleep, float in hardware power down, strobes high except in either sleep state.
  always @(posedge clock)
  begin
    if (reset)
    begin
      portHold            <= 1'b0;
      pinFloat            <= 1'b0;
      addrLatchStrobe     <= 1'b1;
      programFetchStrobeN <= 1'b1;
    end
    else
    begin
      portHold            <= (state_r == ST_IDLE) | (state_r == ST_SLEEP);
      pinFloat            <= (state_r == ST_HOFF);
      addrLatchStrobe     <= ~oscOff(state_r);
      programFetchStrobeN <= ~oscOff(state_r);
    end
  end

  // Mode status flags seen by software and at the ports.
  always @(posedge clock)
  begin
    if (reset)
    begin
      idleActive  <= 1'b0;
      sleepActive <= 1'b0;
      slowActive  <= 1'b0;
    end
    else
    begin
      idleActive  <= (state_r == ST_IDLE);
      sleepActive <= (state_r == ST_SLEEP);
      slowActive  <= slowEff_r;
    end
  end

endmodule

/* tb/psmc_checker.sv */
`timescale 1ns/10ps
// Watches bus timing, mode outputs and clock gating at the controller ports.
module psmc_checker
(
  input wire  clock,
  input wire  reset,
  input wire  wbCyc,
  input wire  wbStb,
  input logic wbAck,
  input wire  resetPin,
  input wire  saveEnableWdogStartPin,
  input logic cpuClockEnable,
  input logic oscEnable,
  input logic rcOscEnable,
  input logic pinFloat,
  input logic addrLatchStrobe,
  input logic programFetchStrobeN,
  input logic idleActive,
  input logic sleepActive
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // A request that is not yet answered, then the answer that follows it.
  sequence s_req; wbCyc && wbStb && !wbAck; endsequence
  sequence s_ack; wbAck ##1 !wbAck; endsequence
  property p_ack; s_req |=> s_ack; endproperty
  property p_cpuGate; idleActive [*2] |-> !cpuClockEnable; endproperty
  property p_strobes; idleActive [*2] |-> addrLatchStrobe && programFetchStrobeN; endproperty
  property p_swOsc; sleepActive [*2] |-> !oscEnable && !rcOscEnable; endproperty
  property p_hwOsc; pinFloat [*2] |-> !oscEnable && !rcOscEnable; endproperty
  property p_block; saveEnableWdogStartPin [*4] |=> !$rose(idleActive) && !$rose(sleepActive);
  endproperty
  property p_rstPin; resetPin [*5] |=> !idleActive && !sleepActive && !pinFloat; endproperty
  property p_noDouble; wbAck |=> !wbAck; endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle after request");
  a_cpuGate: assert property (p_cpuGate) else $error("cpu clock pulse in idle");
  a_strobes: assert property (p_strobes) else $error("strobe low in idle");
  a_swOsc: assert property (p_swOsc) else $error("oscillator on in sleep");
  a_hwOsc: assert property (p_hwOsc) else $error("oscillator on while floating");
  a_block: assert property (p_block) else $error("mode entered while blocked");
  a_rstPin: assert property (p_rstPin) else $error("reset pin did not end mode");
  a_noDouble: assert property (p_noDouble) else $error("ack longer than a cycle");
endmodule

/* tb/psmc_supervisor.sv */
`timescale 1ns/10ps
`include "psmc_defs.vh"
// Supervisor that owns reset, power-down, enable and interrupt pins.
module psmc_supervisor
#(parameter integer OSC_DLY = 40)
(
  input wire  clock,
  output reg  resetPin,
  output reg  hardSleepPinN,
  output reg  saveEnableWdogStartPin,
  output reg  interruptPending,
  output reg  oscStable
);
  integer oscCnt;
  // Pins idle inactive; the enable pin rests high as a pull-up would hold it.
  initial
  begin
    resetPin = 1'b0;
    hardSleepPinN = 1'b1;
    saveEnableWdogStartPin = 1'b1;
    interruptPending = 1'b0;
    oscStable = 1'b1;
    oscCnt = 0;
  end
  // The oscillator dies in hard power down and needs a while to restart.
  always @(posedge clock)
  begin
    oscCnt <= hardSleepPinN ? oscCnt + 1 : 0;
    oscStable <= hardSleepPinN && oscCnt >= OSC_DLY;
  end
  // Reset is held for a number of machine cycles only.
  task holdReset(input integer mc);
  begin
    @(posedge clock);
    resetPin <= 1'b1;
    repeat (mc * `PSMC_MC_CYCLES) @(posedge clock);
    resetPin <= 1'b0;
  end
  endtask
  // Sets the enable and power-down pins together.
  task setPins(input en, input hpdN);
  begin
    @(posedge clock);
    saveEnableWdogStartPin <= en;
    hardSleepPinN <= hpdN;
  end
  endtask
  // Raises an enabled interrupt for two machine cycles.
  task pulseIrq;
  begin
    @(posedge clock);
    interruptPending <= 1'b1;
    repeat (24) @(posedge clock);
    interruptPending <= 1'b0;
  end
  endtask
endmodule

/* tb/test_power_saving_mode_control.sv */
`timescale 1ns/10ps
`include "psmc_defs.vh"
// Self-checking bench for the power saving mode controller.
module test_power_saving_mode_control;
  reg clock = 1'b0, reset = 1'b1, wbWe = 1'b0, wbSel = 1'b0, wbCyc = 1'b0, wbStb = 1'b0;
  reg [7:0] wbAdr = 8'h00, wbDatI = 8'h00, rdat;
  wire [7:0] wbDatO;
  wire wbAck, resetPin, hardSleepPinN, saveEnableWdogStartPin, interruptPending, oscStable;
  wire machineCycleTick, clockOutPin, cpuClockEnable, periphClockEnable, watchdogTick;
  wire watchdogRun, watchdogResetFlag, oscEnable, rcOscEnable, internalReset, portHold;
  wire pinFloat, addrLatchStrobe, programFetchStrobeN, idleActive, sleepActive, slowActive;
  integer n_mismatch = 0, n_compared = 0, g, sdModel = 0;
  psmc_power_saving_mode_control uut (.*);
  psmc_supervisor sup (.clock, .resetPin, .hardSleepPinN, .saveEnableWdogStartPin,
    .interruptPending, .oscStable);
  // Clock of 8 ns period.
  initial
  begin
    forever #4 clock = ~clock;
  end
  // One classic Wishbone cycle, held until ack is sampled high.
  task wb(input [7:0] a, input [7:0] d, input w);
    integer i;
  begin
    @(posedge clock);
    {wbAdr, wbDatI, wbWe, wbSel, wbCyc, wbStb} <= {a, d, w, 3'b111};
    i = 0;
    @(posedge clock);
    while (wbAck !== 1'b1 && i < 50)
    begin
      @(posedge clock);
      i = i + 1;
    end
    rdat = wbDatO;
    {wbWe, wbCyc, wbStb} <= 3'b000;
    if (i == 50) n_mismatch = n_mismatch + 1;
  end
  endtask
  task chk(input string nm, input [7:0] e, input [7:0] s);
  begin
    n_compared = n_compared + 1;
    if (s !== e) n_mismatch = n_mismatch + 1;
    if (s !== e) $display("[FAIL] %s expected %h seen %h", nm, e, s);
  end
  endtask
  // Counts clocks between two machine cycle ticks.
  task gap;
  begin
    g = 0;
    @(posedge clock);
    while (machineCycleTick !== 1'b1 && g < 300) @(posedge clock) g = g + 1;
    g = 0;
    @(posedge clock);
    while (machineCycleTick !== 1'b1 && g < 300) @(posedge clock) g = g + 1;
    g = g + 1;
  end
  endtask
  task tally_and_finish;
  begin
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  // Cuts a hang short.
  initial
  begin
    repeat (20000) @(posedge clock);
    n_mismatch = n_mismatch + 1;
    tally_and_finish;
  end
  // Main sequence of tests.
  initial
  begin
    g = $urandom(32'he79c);
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    repeat (3) @(posedge clock);
    chk("wdogAuto", 8'h01, {7'h00, watchdogRun});
    wb(`PSMC_POWER_CONTROL_OFS, 8'h00, 1'b0);
    chk("pconReset", `PSMC_POWER_CONTROL_RST, rdat);
    g = 8'h90 + ($urandom % 8'h70);
    wb(g[7:0], $urandom, 1'b1);
    wb(g[7:0], 8'h00, 1'b0);
    chk("unmapped", 8'h00, rdat);
    $display("test registers done");
    wb(`PSMC_POWER_CONTROL_OFS, 8'h01, 1'b1);
    sdModel = 1;
    repeat (3 * `PSMC_MC_CYCLES * `PSMC_SD_DIV) @(posedge clock);
    chk("slowOn", 8'h01, {7'h00, slowActive});
    gap;
    chk("slowGap", `PSMC_MC_CYCLES * `PSMC_SD_DIV, g[7:0]);
    wb(`PSMC_POWER_CONTROL_OFS, 8'h00, 1'b0);
    chk("sdKept", sdModel[7:0], rdat & 8'h01);
    wb(`PSMC_POWER_CONTROL_OFS, 8'h00, 1'b1);
    sdModel = 0;
    repeat (300) @(posedge clock);
    gap;
    chk("fullGap", `PSMC_MC_CYCLES, g[7:0]);
    $display("test slow done");
    wb(`PSMC_POWER_CONTROL_OFS, 8'h02, 1'b1);
    wb(`PSMC_POWER_CONTROL_OFS, 8'h04, 1'b1);
    repeat (36) @(posedge clock);
    chk("blocked", 8'h00, {7'h00, idleActive});
    sup.setPins(1'b0, 1'b1);
    repeat (8) @(posedge clock);
    wb(`PSMC_POWER_CONTROL_OFS, 8'h02, 1'b1);
    wb(`PSMC_POWER_CONTROL_OFS, $urandom & 8'he0, 1'b1);
    wb(`PSMC_POWER_CONTROL_OFS, 8'h04, 1'b1);
    repeat (36) @(posedge clock);
    chk("idleBroken", 8'h00, {7'h00, idleActive});
    wb(`PSMC_POWER_CONTROL_OFS, 8'h02, 1'b1);
    wb(`PSMC_POWER_CONTROL_OFS, 8'h04, 1'b1);
    repeat (36) @(posedge clock);
    chk("idleOn", 8'h03, {6'h00, idleActive, portHold});
    chk("idleStrobes", 8'h03, {6'h00, addrLatchStrobe, programFetchStrobeN});
    sup.pulseIrq;
    chk("idleEnd", 8'h00, {7'h00, idleActive});
    $display("test idle done");
    wb(`PSMC_POWER_CONTROL_OFS, 8'h08, 1'b1);
    wb(`PSMC_POWER_CONTROL_OFS, 8'h10, 1'b1);
    repeat (36) @(posedge clock);
    chk("sleepOn", 8'h04, {5'h00, sleepActive, oscEnable, rcOscEnable});
    sup.holdReset(2);
    repeat (36) @(posedge clock);
    chk("sleepEnd", 8'h00, {7'h00, sleepActive});
    $display("test sleep done");
    sup.setPins(1'b1, 1'b0);
    repeat (60) @(posedge clock);
    chk("hwFloat", 8'h04, {5'h00, pinFloat, oscEnable, rcOscEnable});
    sup.setPins(1'b1, 1'b1);
    repeat (400) @(posedge clock);
    chk("hwWake", 8'h01, {6'h00, internalReset, watchdogResetFlag});
    $display("test hard sleep done");
    tally_and_finish;
  end
endmodule
bind psmc_power_saving_mode_control psmc_checker chk (.*);
